// >>> common/sra_pkg.sv
// Shared constants for the receive clock recovery and symbol alignment block
package sra_pkg;
    localparam int VOTE_WIN_UI = 12;
    localparam int STEP_DIV = 48;
    localparam int SETTLE_WIN = 3;
    localparam int LP_SETTLE_UI = 1524;
    localparam int LP_SETTLE_WIN = LP_SETTLE_UI / VOTE_WIN_UI;
    localparam int BLANK_UI = 16;
    localparam int ACC_MAX = 255;
    localparam int REALIGN_MAX_BC = 51;
    localparam int JOG_MAX_BC = 15;
    localparam int WORD_W_MAX = 20;
    localparam int WORD_W_16 = 16;
    localparam int SYM_W = 10;
    localparam int HIST_W = 30;

    localparam logic [2:0] LOOP_LOW_POWER = 3'h7;
    localparam logic [2:0] DESER_W20 = 3'h2;
    localparam logic [2:0] DESER_W16 = 3'h3;
    localparam logic [1:0] ALIGN_OFF = 2'h0;
    localparam logic [1:0] ALIGN_COMMA = 2'h1;
    localparam logic [1:0] ALIGN_JOG = 2'h2;
    localparam logic [1:0] LOSS_DETECT_ON = 2'h2;
    localparam logic [6:0] COMMA_POS = 7'h1F;
    localparam logic [6:0] COMMA_NEG = 7'h60;
endpackage

// >>> common/sra_vote_if.sv
// Window vote results passed from the voter to the loop
`timescale 1ns/10ps
interface sra_vote_if;
    logic       win_done;
    logic [3:0] early_n;
    logic [3:0] late_n;
    modport src (output win_done, output early_n, output late_n);
    modport dst (input win_done, input early_n, input late_n);
endinterface

// >>> hdl/sra_voter.sv
// Early/late voter over one twelve-bit window
`timescale 1ns/10ps
module sra_voter import sra_pkg::*; #(
    parameter int WIN_BITS = VOTE_WIN_UI
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic bit_vld,
    input  wire logic data_bit,
    input  wire logic phase_bit,
    sra_vote_if.src   vote
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] early;
        logic [3:0] late;
        logic       prev_d;
        logic       done;
        logic [3:0] early_o;
        logic [3:0] late_o;
    } sra_vst_s;

    sra_vst_s st_q;
    sra_vst_s st_d;

    if (WIN_BITS < 2 || WIN_BITS > 15) begin : g_chk
        $error("WIN_BITS must fit a four-bit count");
    end

    always_comb begin
        logic [3:0] e_n;
        logic [3:0] l_n;
        st_d = st_q;
        st_d.done = 1'b0;
        e_n = st_q.early;
        l_n = st_q.late;
        if (bit_vld) begin
            // Only a transition carries timing information
            if (st_q.prev_d != data_bit) begin
                if (phase_bit == st_q.prev_d) begin
                    e_n = e_n + 4'h1;
                end else begin
                    l_n = l_n + 4'h1;
                end
            end
            st_d.prev_d = data_bit;
            if (st_q.cnt == 4'(WIN_BITS - 1)) begin
                st_d.cnt = 4'h0;
                st_d.done = 1'b1;
                st_d.early_o = e_n;
                st_d.late_o = l_n;
                st_d.early = 4'h0;
                st_d.late = 4'h0;
            end else begin
                st_d.cnt = st_q.cnt + 4'h1;
                st_d.early = e_n;
                st_d.late = l_n;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign vote.win_done = st_q.done;
    assign vote.early_n = st_q.early_o;
    assign vote.late_n = st_q.late_o;

    a_vote_total: assert property (@(posedge clk) disable iff (rst)
        st_q.done |-> (5'(st_q.early_o) + 5'(st_q.late_o) <= 5'(WIN_BITS)))
        else $error("window votes exceed window size");
    a_window_spacing: assert property (@(posedge clk) disable iff (rst)
        st_q.done |=> !st_q.done)
        else $error("window closed twice in a row");
endmodule

// >>> hdl/sra_rx_top.sv
// Receive clock recovery loop, deserializer and symbol alignment of one lane
//
// What this block does
// - Counter up on late, down on early majority
// - Threshold reached gives one 1/48 UI phase step
// - Ignore three windows after each threshold phase step; accumulator steps do not reload settling
// - Low-power loop code ignores many more windows
// - Each window sums twelve early/late comparisons
// - Phase step follows window close within blanking
// - Second-order accumulator counts threshold crossings
// - Accumulator sign and size drive regular steps
// - Accumulator limited to 255 magnitude steps
// - Width code 010 gives 20, 011 16 bits
// - Alignment select: off, comma, jog, reserved
// - Comma match on top seven symbol bits
// - Misaligned comma realigns word within 51 words
// - Ignore misaligned comma preceded by three MSB copies
// - Sync pulses after aligned comma word output
// - Comma alignment only in 20-bit width
// - Comma off holds alignment, sync stays low
// - Rising select MSB slips alignment one bit
// - Jog realignment done within 15 words
// - Sync high with first realigned word after jog
// - Loop code picks order and vote threshold
// - Phase sample decides early or late vote
`timescale 1ns/10ps
module sra_rx_top import sra_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rx_bit_vld,
    input  wire logic        rx_data_bit,
    input  wire logic        rx_phase_bit,
    input  wire logic [2:0]  recovery_loop_select,
    input  wire logic [2:0]  deser_width_select,
    input  wire logic [1:0]  align_select,
    input  wire logic [1:0]  signal_loss_detect_cfg,
    input  wire logic        loopback_en,
    output logic             phase_step,
    output logic             phase_dir_late,
    output logic [5:0]       phase_code,
    output logic [19:0]      rx_word,
    output logic             rx_word_vld,
    output logic             rx_sync,
    output logic signed [8:0] freq_acc,
    output logic             loss_detect_en
);
    typedef struct packed {
        logic signed [4:0] cnt;
        logic [6:0]        settle;
        logic signed [8:0] acc;
        logic [7:0]        nco;
        logic [5:0]        phase;
        logic              step;
        logic              dir;
        logic [4:0]        bcnt;
        logic [29:0]       hist;
        logic [19:0]       word;
        logic              wvld;
        logic              sync;
        logic              cpend;
        logic              cprev;
        logic              jog_pend;
        logic              jog_sync;
        logic              msb_prev;
    } sra_st_s;

    sra_st_s st_q;
    sra_st_s st_d;

    sra_vote_if vote ();

    sra_voter #(
        .WIN_BITS (VOTE_WIN_UI)
    ) u_voter (
        .clk       (clk),
        .rst       (rst),
        .bit_vld   (rx_bit_vld),
        .data_bit  (rx_data_bit),
        .phase_bit (rx_phase_bit),
        .vote      (vote.src)
    );

    // Vote threshold per loop code
    function automatic logic [4:0] loop_thresh(input logic [2:0] sel);
        case (sel)
            3'h0: loop_thresh = 5'hF;
            3'h1: loop_thresh = 5'h7;
            3'h2: loop_thresh = 5'h3;
            3'h3: loop_thresh = 5'h1;
            3'h4: loop_thresh = 5'hF;
            3'h5: loop_thresh = 5'h3;
            3'h6: loop_thresh = 5'h1;
            default: loop_thresh = 5'h7;
        endcase
    endfunction

    // Modulo-48 phase pointer step
    function automatic logic [5:0] phase_move(input logic [5:0] p, input logic late);
        if (late) begin
            phase_move = (p == 6'(STEP_DIV - 1)) ? 6'h0 : p + 6'h1;
        end else begin
            phase_move = (p == 6'h0) ? 6'(STEP_DIV - 1) : p - 6'h1;
        end
    endfunction

    function automatic logic is_comma(input logic [6:0] top);
        is_comma = (top == COMMA_POS) || (top == COMMA_NEG);
    endfunction

    logic              second_order;
    logic              low_power;
    logic [4:0]        thresh;
    logic              win_use;
    logic signed [4:0] cnt_n;
    logic [4:0]        cnt_mag;
    logic              fo_hit;
    logic              fo_late;
    logic [8:0]        acc_mag;
    logic [8:0]        nco_sum;
    logic              so_hit;
    logic              w20;
    logic [4:0]        word_last;
    logic [29:0]       hist_n;
    logic              comma_seen;
    logic              comma_aligned;
    logic              comma_spurious;
    logic              comma_on;
    logic              realign_now;
    logic              word_end;

    assign second_order = !recovery_loop_select[2];
    assign low_power = recovery_loop_select == LOOP_LOW_POWER;
    assign thresh = loop_thresh(recovery_loop_select);
    assign win_use = vote.win_done && (st_q.settle == 7'h0);

    always_comb begin
        cnt_n = st_q.cnt;
        if (win_use) begin
            if (vote.late_n > vote.early_n) begin
                cnt_n = st_q.cnt + 5'sd1;
            end else if (vote.early_n > vote.late_n) begin
                cnt_n = st_q.cnt - 5'sd1;
            end
        end
    end

    assign cnt_mag = cnt_n[4] ? 5'(-cnt_n) : 5'(cnt_n);
    assign fo_hit = win_use && (cnt_mag >= thresh);
    assign fo_late = !cnt_n[4];
    assign acc_mag = st_q.acc[8] ? 9'(-st_q.acc) : 9'(st_q.acc);
    assign nco_sum = {1'b0, st_q.nco} + acc_mag;
    // Larger accumulator overflows the rate counter more often
    assign so_hit = second_order && vote.win_done && nco_sum[8];

    assign w20 = deser_width_select != DESER_W16;
    assign word_last = w20 ? 5'(WORD_W_MAX - 1) : 5'(WORD_W_16 - 1);
    assign hist_n = {st_q.hist[HIST_W-2:0], rx_data_bit};
    assign comma_seen = is_comma(hist_n[SYM_W-1:3]);
    assign comma_aligned = (st_q.bcnt == 5'(SYM_W - 1)) || (st_q.bcnt == 5'(2 * SYM_W - 1));
    // A K28.7 tail can look like a comma across the boundary
    assign comma_spurious = (hist_n[12:10] == {3{hist_n[9]}});
    assign comma_on = (align_select == ALIGN_COMMA) && w20;
    assign realign_now = rx_bit_vld && comma_on && comma_seen && !comma_aligned
                         && !comma_spurious;
    assign word_end = rx_bit_vld && (st_q.bcnt >= word_last);

    always_comb begin
        logic word_has_comma;
        word_has_comma = 1'b0;
        st_d = st_q;
        st_d.step = 1'b0;
        st_d.wvld = 1'b0;
        st_d.cnt = cnt_n;

        // Settling count only moves on window closes
        if (vote.win_done && st_q.settle != 7'h0) begin
            st_d.settle = st_q.settle - 7'h1;
        end

        // Phase step issued the cycle after the window closes
        if (fo_hit) begin
            st_d.cnt = 5'sd0;
            st_d.step = 1'b1;
            st_d.dir = fo_late;
            st_d.phase = phase_move(st_q.phase, fo_late);
            st_d.settle = low_power ? 7'(LP_SETTLE_WIN) : 7'(SETTLE_WIN);
        end else if (so_hit && st_q.acc != 9'sd0) begin
            st_d.step = 1'b1;
            st_d.dir = !st_q.acc[8];
            st_d.phase = phase_move(st_q.phase, !st_q.acc[8]);
        end

        if (second_order && vote.win_done) begin
            st_d.nco = nco_sum[7:0];
        end
        if (second_order && fo_hit) begin
            if (fo_late && st_q.acc != 9'(ACC_MAX)) begin
                st_d.acc = st_q.acc + 9'sd1;
            end else if (!fo_late && st_q.acc != -9'(ACC_MAX)) begin
                st_d.acc = st_q.acc - 9'sd1;
            end
        end

        // Jog request sampled on each word boundary
        if (word_end) begin
            st_d.msb_prev = align_select[1];
            if (align_select[1] && !st_q.msb_prev) begin
                st_d.jog_pend = 1'b1;
            end
        end

        if (rx_bit_vld) begin
            st_d.hist = hist_n;
            if (realign_now) begin
                // Next word ends ten bits later; this one is corrupt
                st_d.bcnt = 5'(SYM_W);
            end else if (st_q.jog_pend && !word_end) begin
                st_d.bcnt = st_q.bcnt;
                st_d.jog_pend = 1'b0;
                st_d.jog_sync = 1'b1;
            end else if (word_end) begin
                st_d.bcnt = 5'h0;
            end else begin
                st_d.bcnt = st_q.bcnt + 5'h1;
            end
            if (comma_on && comma_seen && comma_aligned) begin
                word_has_comma = 1'b1;
            end
        end

        if (word_end) begin
            st_d.wvld = 1'b1;
            st_d.word = w20 ? hist_n[19:0] : {4'h0, hist_n[15:0]};
            st_d.sync = (st_q.cprev && comma_on) || st_q.jog_sync;
            st_d.jog_sync = 1'b0;
            st_d.cprev = st_q.cpend || word_has_comma;
            st_d.cpend = 1'b0;
        end else if (word_has_comma) begin
            st_d.cpend = 1'b1;
        end
        if (!comma_on && !st_q.jog_sync && word_end) begin
            st_d.cprev = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign phase_step = st_q.step;
    assign phase_dir_late = st_q.dir;
    assign phase_code = st_q.phase;
    assign rx_word = st_q.word;
    assign rx_word_vld = st_q.wvld;
    assign rx_sync = st_q.sync;
    assign freq_acc = st_q.acc;
    assign loss_detect_en = (signal_loss_detect_cfg == LOSS_DETECT_ON) && !loopback_en;

    sequence s_jog_req;
        $rose(st_q.jog_pend);
    endsequence

    sequence s_jog_sync;
        st_q.wvld && st_q.sync;
    endsequence

    a_late_count: assert property (@(posedge clk) disable iff (rst)
        win_use && !fo_hit && vote.late_n > vote.early_n |=> st_q.cnt == $past(st_q.cnt) + 5'sd1)
        else $error("late majority did not raise counter");
    a_tie_hold: assert property (@(posedge clk) disable iff (rst)
        win_use && vote.late_n == vote.early_n |=> st_q.cnt == $past(st_q.cnt))
        else $error("tie changed counter");
    a_thresh_step: assert property (@(posedge clk) disable iff (rst)
        fo_hit |=> phase_step && phase_dir_late == $past(fo_late) && st_q.cnt == 5'sd0)
        else $error("threshold did not give a phase step");
    a_settle_load: assert property (@(posedge clk) disable iff (rst)
        fo_hit && !low_power |=> st_q.settle == 7'(SETTLE_WIN))
        else $error("settling windows not loaded");
    a_lp_settle: assert property (@(posedge clk) disable iff (rst)
        fo_hit && low_power |=> st_q.settle == 7'(LP_SETTLE_WIN))
        else $error("low-power settling not loaded");
    a_discard_win: assert property (@(posedge clk) disable iff (rst)
        vote.win_done && st_q.settle != 7'h0 |=> !phase_step || $past(so_hit))
        else $error("window used while settling");
    a_acc_range: assert property (@(posedge clk) disable iff (rst)
        (st_q.acc <= 9'sd255) && (st_q.acc >= -9'sd255))
        else $error("accumulator beyond 255 steps");
    a_comma_gate: assert property (@(posedge clk) disable iff (rst)
        realign_now |-> align_select == ALIGN_COMMA && deser_width_select != DESER_W16
                        ##1 st_q.bcnt == 5'(SYM_W))
        else $error("comma realignment outside comma mode");
    a_jog_sync: assert property (@(posedge clk) disable iff (rst)
        s_jog_req ##0 (rx_bit_vld [*8]) |-> ##[1:400] s_jog_sync)
        else $error("jog did not complete with sync");
endmodule

// >>> dv/sra_tx_model.sv
// Remote serial transmitter model feeding one lane as data and edge samples
`timescale 1ns/10ps
module sra_tx_model (
    input  wire logic clk,
    input  wire logic late_mode,
    output logic      rx_bit_vld,
    output logic      rx_data_bit,
    output logic      rx_phase_bit
);
    logic prev_bit;

    initial begin
        rx_bit_vld   = 1'b0;
        rx_data_bit  = 1'b0;
        rx_phase_bit = 1'b1;
        prev_bit     = 1'b0;
    end

    // Sends the low n bits of w, first bit at the top
    task automatic send(input logic [19:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            rx_bit_vld   = 1'b1;
            rx_data_bit  = w[i];
            rx_phase_bit = late_mode ? w[i] : prev_bit;
            prev_bit     = w[i];
        end
    endtask

    // Lines left undriven by the far end must not keep the last value
    task automatic idle();
        @(negedge clk);
        rx_bit_vld   = 1'b0;
        rx_data_bit  = ~rx_data_bit;
        rx_phase_bit = ~rx_phase_bit;
    endtask
endmodule

// >>> dv/sra_rx_top_tb_top.sv
// Self-checking testbench for the lane receive recovery and alignment block
`timescale 1ns/10ps
module sra_rx_top_tb_top import sra_pkg::*; ;
    localparam logic [19:0] K_PAIR = 20'h3EB05;
    localparam logic [19:0] K_ONE  = 20'h3E800;
    localparam logic [19:0] ROL1   = {K_PAIR[18:0], K_PAIR[19]};
    localparam logic [19:0] ROL2   = {K_PAIR[17:0], K_PAIR[19:18]};
    logic              clk, rst, lb, late_mode, sync, wvld, step, dir, los_en;
    logic [2:0]        loop_sel, width_sel;
    logic [1:0]        align_sel, los_cfg;
    logic [5:0]        pcode;
    logic [19:0]       word, g;
    logic signed [8:0] acc;
    logic              vld, dbit, pbit, s;
    int                fail_count, n_tests, steps, hits, syncs, k;
    int                exp_steps [8] = '{0, 1, 2, 3, 0, 2, 3, 1};

    sra_tx_model tx (.clk(clk), .late_mode(late_mode), .rx_bit_vld(vld), .rx_data_bit(dbit),
        .rx_phase_bit(pbit));
    sra_rx_top DUT (.clk(clk), .rst(rst), .rx_bit_vld(vld), .rx_data_bit(dbit),
        .rx_phase_bit(pbit), .recovery_loop_select(loop_sel), .deser_width_select(width_sel),
        .align_select(align_sel), .signal_loss_detect_cfg(los_cfg), .loopback_en(lb),
        .phase_step(step), .phase_dir_late(dir), .phase_code(pcode), .rx_word(word),
        .rx_word_vld(wvld), .rx_sync(sync), .freq_acc(acc), .loss_detect_en(los_en));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (step === 1'b1) steps <= steps + 1;
    end

    task automatic chk_v(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp, input string what);
        n_tests++;
        if (got != exp) begin
            fail_count++;
            $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] l, input logic [2:0] w, input logic [1:0] a);
        @(negedge clk);
        rst       = 1'b1;
        loop_sel  = l;
        width_sel = w;
        align_sel = a;
        repeat (5) @(negedge clk);
        rst   = 1'b0;
        steps = 0;
    endtask

    // Bounded wait for the next word strobe
    task automatic get_word(output logic [19:0] w, output logic sy);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wvld !== 1'b1 && n < 60);
        chk_v({19'h0, wvld}, 20'h1, "word strobe");
        w  = word;
        sy = sync;
    endtask

    task automatic scan(input int n, input logic [19:0] w);
        hits  = 0;
        syncs = 0;
        repeat (n) begin
            get_word(g, s);
            if (g === w) hits++;
            if (s === 1'b1) syncs++;
        end
    endtask

    task automatic stream(input logic [19:0] pre, input int pl, input logic [19:0] w, input int nw);
        if (pl > 0) tx.send(pre, pl);
        repeat (nw) tx.send(w, 20);
        tx.idle();
    endtask

    task automatic comma_case(input logic [2:0] wd, input logic [1:0] al, input int pl,
        input logic [19:0] w, input logic [19:0] tgt, input int eh, input int es);
        do_reset(3'h6, wd, al);
        fork
            stream(20'h0, pl, w, 24);
            scan(20, tgt);
        join
        chk_n(hits, eh, "matching words");
        chk_n(syncs, es, "sync words");
    endtask

    initial begin
        #300000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end

    initial begin
        {rst, lb, late_mode} = 3'h5;
        {loop_sel, width_sel, align_sel, los_cfg} = {3'h6, DESER_W20, ALIGN_OFF, 2'h0};
        {fail_count, n_tests, steps} = 0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            {lb, los_cfg} = i[2:0];
            #1;
            chk_v({19'h0, los_en}, {19'h0, i == 2}, "loss detect enable");
        end
        // Nine late windows: threshold 1, 3, 7 give 3, 2, 1 steps, 15 gives none
        for (int c = 7; c >= 0; c--) begin
            do_reset(c[2:0], DESER_W20, ALIGN_OFF);
            repeat (5) tx.send(20'hAAAAA, 20);
            tx.send(20'hAA, 8);
            tx.idle();
            repeat (4) @(negedge clk);
            chk_n(steps, exp_steps[c], "late steps");
            chk_v({14'h0, pcode}, 20'(exp_steps[c]), "phase code");
            chk_v({11'h0, acc}, c < 4 ? 20'(exp_steps[c]) : 20'h0, "accumulator");
        end
        // Two first-order steps leave acc 2; one rate carry in 200 quiet windows
        do_reset(3'h3, DESER_W20, ALIGN_OFF);
        repeat (3) tx.send(20'hAAAAA, 20);
        repeat (120) tx.send(20'h0, 20);
        tx.idle();
        repeat (4) @(negedge clk);
        chk_n(steps, 3, "second-order steps");
        chk_v({11'h0, acc}, 20'h2, "held accumulator");
        chk_v({13'h0, dir, pcode}, 20'h43, "second-order phase");
        do_reset(3'h6, DESER_W20, ALIGN_OFF);
        chk_v({acc, pcode, sync, 4'h0}, 20'h0, "reset state");
        chk_v(word, 20'h0, "reset word");
        late_mode = 1'b0;
        tx.send(20'hAAA, 12);
        tx.idle();
        k = 0;
        while (steps == 0 && k < 16) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_n(steps, 1, "step within blanking");
        repeat (4) tx.send(20'hAAAAA, 20);
        tx.send(20'hAAAA, 16);
        tx.idle();
        repeat (4) @(negedge clk);
        chk_n(steps, 3, "early steps");
        chk_v({13'h0, dir, pcode}, 20'd45, "early wrap");
        do_reset(3'h6, DESER_W16, ALIGN_OFF);
        fork
            stream(20'h0, 0, 20'hC3A5C, 2);
            begin
                get_word(g, s);
                chk_v(g, 20'h0C3A5, "first narrow word");
                get_word(g, s);
                chk_v(g, 20'h0CC3A, "second narrow word");
            end
        join
        comma_case(DESER_W20, ALIGN_COMMA, 0, K_PAIR, K_PAIR, 20, 19);
        comma_case(DESER_W20, ALIGN_OFF, 0, K_PAIR, K_PAIR, 20, 0);
        comma_case(DESER_W16, ALIGN_COMMA, 3, K_PAIR, K_PAIR, 0, 0);
        comma_case(DESER_W20, ALIGN_COMMA, 3, K_ONE, 20'h07D00, 20, 0);
        do_reset(3'h6, DESER_W20, ALIGN_COMMA);
        fork
            stream(20'h5, 3, K_PAIR, 60);
            scan(51, K_PAIR);
        join
        chk_n(int'(hits > 0 && syncs > 0), 1, "comma realign");
        do_reset(3'h6, DESER_W20, ALIGN_OFF);
        fork
            stream(20'h0, 0, K_PAIR, 80);
            begin
                scan(3, K_PAIR);
                @(negedge clk);
                align_sel = ALIGN_JOG;
                scan(15, ROL1);
                chk_n(int'(hits > 0), 1, "first jog");
                chk_n(syncs, 1, "first jog sync");
                @(negedge clk);
                align_sel = ALIGN_OFF;
                scan(2, ROL1);
                @(negedge clk);
                align_sel = ALIGN_JOG;
                scan(15, ROL2);
                chk_n(int'(hits > 0), 1, "second jog");
                chk_n(syncs, 1, "second jog sync");
            end
        join
        results();
    end
endmodule
